// File: inc/fc_sel_pkg.sv
/*
  Constants for the port 2 flow-control select register: offset, bit positions,
  widths. Assumes a simple word-wide register access port inside the switch.
*/
package fc_sel_pkg;
  localparam int          addr_width    = 12;
  localparam int          data_width    = 32;
  localparam logic [11:0] fc_sel_offset = 12'h1a4;
  localparam int          bit_bp        = 6;
  localparam int          bit_dup       = 5;
  localparam int          bit_cur_rx    = 4;
  localparam int          bit_cur_tx    = 3;
  localparam int          bit_rx_en     = 2;
  localparam int          bit_tx_en     = 1;
  localparam int          bit_manual    = 0;
  localparam logic [31:0] zero_word     = 32'h0000_0000;
endpackage : fc_sel_pkg

// File: hw/strap_hold.sv
/*
  One strap-backed writable bit. Takes its strap value one cycle after reset
  release and on every loader reload; software writes otherwise.
*/
module strap_hold
  import fc_sel_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic load,
  input  wire logic strap,
  input  wire logic wr,
  input  wire logic wdata,
  output logic      q
);
  logic q_reg;
  logic q_next;

  // strap taken by clocked load, not by reset
  // reload overrides, loader wins over a write
  always_comb
  begin
    q_next = q_reg;
    if (load)
      q_next = strap;
    else if (wr)
      q_next = wdata;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      q_reg <= 1'b0;
    else
      q_reg <= q_next;
  end

  assign q = q_reg;
endmodule : strap_hold

// File: hw/fc_resolve.sv
/*
  Pure resolution of the flow-control state in effect for the port.
  Assumes duplex and negotiation results come from the port MAC/PHY.
*/
module fc_resolve
(
  input  wire logic manual_sel,
  input  wire logic an_enable,
  input  wire logic half_duplex,
  input  wire logic man_rx,
  input  wire logic man_tx,
  input  wire logic an_rx,
  input  wire logic an_tx,
  output logic      rx_on,
  output logic      tx_on
);
  always_comb
  begin
    rx_on = 1'b0;
    tx_on = 1'b0;
    // pause frames have no meaning in half duplex
    if (!half_duplex)
    begin
      if (manual_sel)
      begin
        rx_on = man_rx;
        tx_on = man_tx;
      end
      else if (an_enable)
      begin
        rx_on = an_rx;
        tx_on = an_tx;
      end
      else
      begin
        rx_on = man_rx;
        tx_on = man_tx;
      end
    end
  end
endmodule : fc_resolve

// File: hw/port2_flow_control_select.sv
/*
  Port 2 flow-control select and status register. Read and write through the
  switch's internal register port (address, read/write strobes, read data the
  next cycle). Straps are stable around reset release and across strap_reload.
*/
module port2_flow_control_select
  import fc_sel_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic [addr_width-1:0] reg_addr,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic [data_width-1:0] reg_wdata,
  output logic      [data_width-1:0] reg_rdata,
  input  wire logic                  p2_backpressure_strap,
  input  wire logic                  p2_full_duplex_pause_strap,
  input  wire logic                  p2_manual_select_strap,
  input  wire logic                  strap_reload,
  input  wire logic                  an_enable,
  input  wire logic                  half_duplex,
  input  wire logic                  an_rx_pause,
  input  wire logic                  an_tx_pause,
  output logic                       p2_backpressure_enable,
  output logic                       p2_current_duplex,
  output logic                       p2_current_rx_pause_on,
  output logic                       p2_current_tx_pause_on
);
  logic                  boot_reg;
  logic                  boot_next;
  logic                  load;
  logic                  hit_wr;
  logic                  bp_q;
  logic                  rx_q;
  logic                  tx_q;
  logic                  man_q;
  logic                  rx_on;
  logic                  tx_on;
  logic                  dup_reg;
  logic                  dup_next;
  logic                  crx_reg;
  logic                  crx_next;
  logic                  ctx_reg;
  logic                  ctx_next;
  logic                  bpo_reg;
  logic                  bpo_next;
  logic [data_width-1:0] rdata_reg;
  logic [data_width-1:0] rdata_next;
  logic [data_width-1:0] word;

  // first cycle after reset release latches straps
  always_comb
  begin
    boot_next = 1'b0;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      boot_reg <= 1'b1;
    else
      boot_reg <= boot_next;
  end

  assign load   = boot_reg | strap_reload;
  // only this word decodes; nothing else is written
  assign hit_wr = reg_wr && (reg_addr == fc_sel_offset);

  strap_hold u_bp
  (
    .clk   (clk),
    .rst   (rst),
    .load  (load),
    .strap (p2_backpressure_strap),
    .wr    (hit_wr),
    .wdata (reg_wdata[bit_bp]),
    .q     (bp_q)
  );

  strap_hold u_rx
  (
    .clk   (clk),
    .rst   (rst),
    .load  (load),
    .strap (p2_full_duplex_pause_strap),
    .wr    (hit_wr),
    .wdata (reg_wdata[bit_rx_en]),
    .q     (rx_q)
  );

  strap_hold u_tx
  (
    .clk   (clk),
    .rst   (rst),
    .load  (load),
    .strap (p2_full_duplex_pause_strap),
    .wr    (hit_wr),
    .wdata (reg_wdata[bit_tx_en]),
    .q     (tx_q)
  );

  strap_hold u_man
  (
    .clk   (clk),
    .rst   (rst),
    .load  (load),
    .strap (p2_manual_select_strap),
    .wr    (hit_wr),
    .wdata (reg_wdata[bit_manual]),
    .q     (man_q)
  );

  fc_resolve u_res
  (
    .manual_sel  (man_q),
    .an_enable   (an_enable),
    .half_duplex (half_duplex),
    .man_rx      (rx_q),
    .man_tx      (tx_q),
    .an_rx       (an_rx_pause),
    .an_tx       (an_tx_pause),
    .rx_on       (rx_on),
    .tx_on       (tx_on)
  );

  // status follows the strap-loaded or software-written settings and live link state
  always_comb
  begin
    dup_next = half_duplex;
    crx_next = rx_on;
    ctx_next = tx_on;
    bpo_next = bp_q;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dup_reg <= 1'b0;
      crx_reg <= 1'b0;
      ctx_reg <= 1'b0;
      bpo_reg <= 1'b0;
    end
    else
    begin
      dup_reg <= dup_next;
      crx_reg <= crx_next;
      ctx_reg <= ctx_next;
      bpo_reg <= bpo_next;
    end
  end

  // status and reserved bits come from state only
  always_comb
  begin
    word             = zero_word;
    word[bit_bp]     = bp_q;
    word[bit_dup]    = dup_reg;
    word[bit_cur_rx] = crx_reg;
    word[bit_cur_tx] = ctx_reg;
    word[bit_rx_en]  = rx_q;
    word[bit_tx_en]  = tx_q;
    word[bit_manual] = man_q;
    rdata_next       = zero_word;
    if (reg_rd && (reg_addr == fc_sel_offset))
      rdata_next = word;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata_reg <= zero_word;
    else
      rdata_reg <= rdata_next;
  end

  assign reg_rdata              = rdata_reg;
  assign p2_backpressure_enable = bpo_reg;
  assign p2_current_duplex      = dup_reg;
  assign p2_current_rx_pause_on = crx_reg;
  assign p2_current_tx_pause_on = ctx_reg;

  // boot cycle still shows reset values, so checks start after it
  sequence s_full_manual;
    man_q && !half_duplex;
  endsequence

  sequence s_full_auto;
    !man_q && an_enable && !half_duplex;
  endsequence

  sequence s_full_fixed;
    !man_q && !an_enable && !half_duplex;
  endsequence

  sequence s_sw_write;
    hit_wr && !load;
  endsequence

  sequence s_read_hit;
    reg_rd && (reg_addr == fc_sel_offset);
  endsequence

  a_manual_follow: assert property (@(posedge clk) disable iff (rst || boot_reg)
    s_full_manual |=> (p2_current_rx_pause_on == $past(rx_q)))
    else $error("manual receive pause not followed");

  a_manual_tx_follow: assert property (@(posedge clk) disable iff (rst || boot_reg)
    s_full_manual |=> (p2_current_tx_pause_on == $past(tx_q)))
    else $error("manual transmit pause not followed");

  a_auto_follow: assert property (@(posedge clk) disable iff (rst || boot_reg)
    s_full_auto |=> (p2_current_tx_pause_on == $past(an_tx_pause)))
    else $error("negotiated transmit pause not followed");

  a_auto_rx_follow: assert property (@(posedge clk) disable iff (rst || boot_reg)
    s_full_auto |=> (p2_current_rx_pause_on == $past(an_rx_pause)))
    else $error("negotiated receive pause not followed");

  a_auto_off: assert property (@(posedge clk) disable iff (rst || boot_reg)
    s_full_fixed |=> (p2_current_tx_pause_on == $past(tx_q)))
    else $error("manual transmit pause not used with negotiation off");

  a_auto_off_rx: assert property (@(posedge clk) disable iff (rst || boot_reg)
    s_full_fixed |=> (p2_current_rx_pause_on == $past(rx_q)))
    else $error("manual receive pause not used with negotiation off");

  a_duplex_track: assert property (@(posedge clk) disable iff (rst || boot_reg)
    1'b1 |=> (p2_current_duplex == $past(half_duplex)))
    else $error("duplex status wrong");

  a_half_no_pause: assert property (@(posedge clk) disable iff (rst || boot_reg)
    half_duplex |=> !p2_current_rx_pause_on && !p2_current_tx_pause_on)
    else $error("pause shown in half duplex");

  a_bp_write: assert property (@(posedge clk) disable iff (rst || boot_reg)
    s_sw_write ##1 !load |=> (p2_backpressure_enable == $past(reg_wdata[bit_bp], 2)))
    else $error("backpressure write not applied");

  a_bp_output: assert property (@(posedge clk) disable iff (rst || boot_reg)
    1'b1 |=> (p2_backpressure_enable == $past(bp_q)))
    else $error("backpressure output does not follow field");

  a_rx_write: assert property (@(posedge clk) disable iff (rst || boot_reg)
    s_sw_write |=> (rx_q == $past(reg_wdata[bit_rx_en])))
    else $error("receive enable write not applied");

  a_tx_write: assert property (@(posedge clk) disable iff (rst || boot_reg)
    s_sw_write |=> (tx_q == $past(reg_wdata[bit_tx_en])))
    else $error("transmit enable write not applied");

  a_select_write: assert property (@(posedge clk) disable iff (rst || boot_reg)
    s_sw_write |=> (man_q == $past(reg_wdata[bit_manual])))
    else $error("manual select write not applied");

  a_strap_reload: assert property (@(posedge clk) disable iff (rst || boot_reg)
    strap_reload |=> (rx_q == $past(p2_full_duplex_pause_strap)) && (man_q == $past(p2_manual_select_strap)))
    else $error("strap reload not applied");

  a_reload_bp: assert property (@(posedge clk) disable iff (rst || boot_reg)
    strap_reload |=> (bp_q == $past(p2_backpressure_strap)) && (tx_q == $past(p2_full_duplex_pause_strap)))
    else $error("strap reload lost to a write");

  a_reserved_zero: assert property (@(posedge clk) disable iff (rst || boot_reg)
    reg_rdata[data_width-1:bit_bp+1] == '0)
    else $error("reserved bits not zero");

  a_read_miss: assert property (@(posedge clk) disable iff (rst || boot_reg)
    !(reg_rd && (reg_addr == fc_sel_offset)) |=> (reg_rdata == zero_word))
    else $error("read data not zero without a read");

  a_read_status: assert property (@(posedge clk) disable iff (rst || boot_reg)
    s_read_hit |=> (reg_rdata[bit_cur_tx] == $past(p2_current_tx_pause_on))
                && (reg_rdata[bit_cur_rx] == $past(p2_current_rx_pause_on))
                && (reg_rdata[bit_dup] == $past(p2_current_duplex)))
    else $error("status bits read wrong");

  a_read_fields: assert property (@(posedge clk) disable iff (rst || boot_reg)
    s_read_hit |=> (reg_rdata[bit_bp] == $past(bp_q))
                && (reg_rdata[bit_rx_en] == $past(rx_q))
                && (reg_rdata[bit_manual] == $past(man_q)))
    else $error("writable fields read wrong");

  a_strap_boot: assert property (@(posedge clk) disable iff (rst || boot_reg)
    $fell(boot_reg) |-> (bp_q == $past(p2_backpressure_strap))
                     && (rx_q == $past(p2_full_duplex_pause_strap))
                     && (man_q == $past(p2_manual_select_strap)))
    else $error("straps not latched after reset");
endmodule : port2_flow_control_select

// File: bench/test_port2_flow_control_select.sv
/*
  Self-checking bench for the port 2 flow-control select register.
  Assumes the design's register port: one-cycle strobes, read data the cycle after.
*/
module test_port2_flow_control_select
  import fc_sel_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  clk, rst, reg_wr, reg_rd, strap_reload, an_enable, half_duplex, an_rx_pause, an_tx_pause;
  logic                  p2_backpressure_strap, p2_full_duplex_pause_strap, p2_manual_select_strap;
  logic [addr_width-1:0] reg_addr;
  logic [data_width-1:0] reg_wdata, reg_rdata, word;
  logic                  p2_backpressure_enable, p2_current_duplex, p2_current_rx_pause_on, p2_current_tx_pause_on;
  logic [7:0]            v;
  int                    fails, checked;

  port2_flow_control_select port2_flow_control_select_inst
  (
    .clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .p2_backpressure_strap, .p2_full_duplex_pause_strap, .p2_manual_select_strap,
    .strap_reload, .an_enable, .half_duplex, .an_rx_pause, .an_tx_pause,
    .p2_backpressure_enable, .p2_current_duplex, .p2_current_rx_pause_on, .p2_current_tx_pause_on
  );

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  // expected word from field values and link state; half duplex kills pause
  function automatic logic [31:0] expw(input logic bp, rxe, txe, man, ane, hd, arx, atx);
    logic r, t;
    r = hd ? 1'b0 : ((man | ~ane) ? rxe : arx);
    t = hd ? 1'b0 : ((man | ~ane) ? txe : atx);
    return {25'h0, bp, hd, r, t, rxe, txe, man};
  endfunction : expw

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd

  task automatic ports(input logic [31:0] e);
    chk({28'h0, p2_backpressure_enable, p2_current_duplex, p2_current_rx_pause_on, p2_current_tx_pause_on},
        {28'h0, e[6:3]});
  endtask : ports

  task automatic do_reset(input logic bp, input logic fd, input logic man);
    @(posedge clk);
    p2_backpressure_strap      <= bp;
    p2_full_duplex_pause_strap <= fd;
    p2_manual_select_strap     <= man;
    rst                        <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // first edge after release is the strap load; requests wait past it
    repeat (2) @(posedge clk);
  endtask : do_reset

  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    end_of_test();
  end

  initial
  begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 12'h0;
    reg_wdata = 32'h0;
    strap_reload = 1'b0;
    an_enable = 1'b1;
    half_duplex = 1'b0;
    an_rx_pause = 1'b0;
    an_tx_pause = 1'b1;
    p2_backpressure_strap = 1'b0;
    p2_full_duplex_pause_strap = 1'b0;
    p2_manual_select_strap = 1'b0;
    do_reset(1'b1, 1'b1, 1'b0);
    word = expw(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    rd(fc_sel_offset, word);
    ports(word);
    $display("test defaults done");
    wr(fc_sel_offset, 32'hffff_ffff);
    repeat (2) @(posedge clk);
    word = expw(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
    rd(fc_sel_offset, word);
    wr(12'h1a0, 32'h0);
    rd(12'h1a0, 32'h0);
    rd(fc_sel_offset, word);
    $display("test access done");
    for (int i = 0; i < 256; i++)
    begin
      v = i[7:0];
      @(posedge clk);
      an_enable   <= v[3];
      half_duplex <= v[2];
      an_rx_pause <= v[1];
      an_tx_pause <= v[0];
      wr(fc_sel_offset, {25'h1ff_ffff, v[7], 3'b111, v[6:4]});
      repeat (2) @(posedge clk);
      word = expw(v[7], v[6], v[5], v[4], v[3], v[2], v[1], v[0]);
      rd(fc_sel_offset, word);
      ports(word);
    end
    $display("test resolve done");
    @(posedge clk);
    an_enable <= 1'b0;
    half_duplex <= 1'b0;
    p2_backpressure_strap <= 1'b0;
    p2_full_duplex_pause_strap <= 1'b0;
    p2_manual_select_strap <= 1'b1;
    @(posedge clk);
    strap_reload <= 1'b1;
    reg_addr <= fc_sel_offset;
    reg_wdata <= 32'hffff_ffff;
    reg_wr <= 1'b1;
    @(posedge clk);
    strap_reload <= 1'b0;
    reg_wr <= 1'b0;
    repeat (2) @(posedge clk);
    word = expw(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    rd(fc_sel_offset, word);
    ports(word);
    $display("test reload done");
    do_reset(1'b0, 1'b1, 1'b1);
    word = expw(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    rd(fc_sel_offset, word);
    ports(word);
    $display("test second reset done");
    end_of_test();
  end
endmodule : test_port2_flow_control_select
